/* File: pdt_consts.vh */
`ifndef PDT_CONSTS_VH
`define PDT_CONSTS_VH

// timer configuration registers, one word per timer
`define PDT_TMR_BASE 8'h00
// channel-to-timer routing (pwm_timer_select_1)
`define PDT_TMRSEL 8'h0C
// channel register blocks
`define PDT_CH_BASE 8'h10
`define PDT_CH_CTRL 4'h0
`define PDT_CH_DUTYL 4'h4
`define PDT_CH_DUTYH 4'h8

// timer word fields
`define PDT_TMR_PER_LSB 0
`define PDT_TMR_PSC_LSB 8
`define PDT_TMR_RUN_BIT 10
`define PDT_TMR_CNT_LSB 16

// channel control word fields
`define PDT_CH_EN_BIT 0
`define PDT_CH_FMT_BIT 1
`define PDT_CH_PIN_BIT 8
`define PDT_CH_BUF_LSB 16

// reset values
`define PDT_PER_RST 8'hFF
`define PDT_PSC_RST 2'h0
`define PDT_TMRSEL_RST 8'h55

// prescale codes: 1:1, 1:4, 1:16, 1:64
`define PDT_PSC_1 2'h0
`define PDT_PSC_4 2'h1
`define PDT_PSC_16 2'h2
`define PDT_PSC_64 2'h3

// oscillator phases per timer step at 1:1
`define PDT_PHASES 8'h04

`endif

/* File: pdt_pwm_duty_timebase.v */
//
// Contract
// [RL1] duty is 10 bits from high/low byte pair
// [RL2] format bit picks left or right alignment
// [RL3] duty buffer reloads only on period match
// [RL4] high time is duty times osc times prescale
// [RL5] ratio is duty over four times period+1
// [RL6] time base is count plus two low bits
// [RL7] low bits from clock phase at 1:1
// [RL8] pin goes low when time base equals duty
// [RL9] resolution is log2 of 4(period+1) bits
// [RL10] duty beyond period leaves pin unchanged
// [RL11] select 01/10/11 picks timer one/two/three
// [RL12] four select fields, each resetting to 01
// [RL13] pin high at period start unless duty zero
`timescale 1ns/100ps
`include "pdt_consts.vh"

module pdt_pwm_duty_timebase #(
    parameter NUM_CH = 4,
    parameter NUM_TMR = 3,
    parameter ADDR_W = 8
) (
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire [NUM_CH-1:0] pwm_out_pin
);

////////////////////////////////////////////////////////////////////////////////
// address helpers

function [7:0] tmr_addr;
    input integer k;
    begin
        tmr_addr = `PDT_TMR_BASE + {k[5:0], 2'b00};
    end
endfunction

function [7:0] ch_addr;
    input integer k;
    input [3:0] off;
    begin
        ch_addr = `PDT_CH_BASE + {k[3:0], off};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// apb access

wire [7:0] addr8;
wire wr_en;
reg [31:0] rdata_nxt;
reg mapped_nxt;
reg [31:0] prdata_r;
reg [7:0] tmrsel_r;
wire [10*NUM_TMR-1:0] tb_w;
wire [NUM_TMR-1:0] pm_w;
wire [8*NUM_TMR-1:0] per_w;
wire [11*NUM_TMR-1:0] tcfg_w;
wire [NUM_TMR*8-1:0] cnt_w;
wire [28*NUM_CH-1:0] chrd_w;
wire [16*NUM_CH-1:0] duty_w;
integer k;

assign addr8 = paddr[7:0];
assign wr_en = psel & penable & pwrite & mapped_nxt;
assign pready = psel & penable;
assign pslverr = psel & penable & ~mapped_nxt;
assign prdata = prdata_r;

always @*
begin
    rdata_nxt = 32'h00000000;
    mapped_nxt = 1'b0;
    for (k = 0; k < NUM_TMR; k = k + 1)
    begin
        if (addr8 == tmr_addr(k))
        begin
            mapped_nxt = 1'b1;
            rdata_nxt = {8'h00, cnt_w[8*k +: 8], 5'h00, tcfg_w[11*k +: 11]};
        end
    end
    if (addr8 == `PDT_TMRSEL)
    begin
        mapped_nxt = 1'b1;
        rdata_nxt = {24'h000000, tmrsel_r};
    end
    for (k = 0; k < NUM_CH; k = k + 1)
    begin
        if (addr8 == ch_addr(k, `PDT_CH_CTRL))
        begin
            mapped_nxt = 1'b1;
            rdata_nxt = {6'h00, chrd_w[28*k +: 10], 7'h00, chrd_w[28*k+10], 6'h00, chrd_w[28*k+11 +: 2]};
        end
        if (addr8 == ch_addr(k, `PDT_CH_DUTYL))
        begin
            mapped_nxt = 1'b1;
            rdata_nxt = {24'h000000, duty_w[16*k +: 8]};
        end
        if (addr8 == ch_addr(k, `PDT_CH_DUTYH))
        begin
            mapped_nxt = 1'b1;
            rdata_nxt = {24'h000000, duty_w[16*k+8 +: 8]};
        end
    end
    if ((paddr >> 8) != {ADDR_W{1'b0}})
    begin
        mapped_nxt = 1'b0;
        rdata_nxt = 32'h00000000;
    end
end

// read data captured in the setup cycle
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
        prdata_r <= 32'h00000000;
    else if (psel & ~penable)
        prdata_r <= rdata_nxt;
end

// channel routing register
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
        tmrsel_r <= `PDT_TMRSEL_RST; // RL12
    else if (wr_en & pstrb[0] & (addr8 == `PDT_TMRSEL))
        tmrsel_r <= pwdata[7:0]; // RL12
end

////////////////////////////////////////////////////////////////////////////////
// 8-bit timers with 2-bit time base extension

genvar gi;
generate
    for (gi = 0; gi < NUM_TMR; gi = gi + 1)
    begin : g_tmr
        reg [7:0] per_r;
        reg [1:0] psc_r;
        reg run_r;
        reg [7:0] sub_r;
        reg [7:0] cnt_r;
        reg [7:0] sub_last;
        wire [1:0] ext;
        wire [7:0] sub_nxt;
        wire [7:0] cnt_nxt;
        wire tick;
        wire sel_w;

        assign sel_w = wr_en & (addr8 == tmr_addr(gi));
        assign tick = run_r & (sub_r == sub_last);
        assign sub_nxt = (run_r & ~tick) ? sub_r + 8'h01 : 8'h00;
        assign cnt_nxt = !run_r ? 8'h00 : !tick ? cnt_r : (cnt_r == per_r) ? 8'h00 : cnt_r + 8'h01; // RL5 RL9

        // step every 4*prescale clocks
        always @*
        begin
            case (psc_r)
                `PDT_PSC_1: sub_last = `PDT_PHASES - 8'h01;
                `PDT_PSC_4: sub_last = (`PDT_PHASES << 2) - 8'h01;
                `PDT_PSC_16: sub_last = (`PDT_PHASES << 4) - 8'h01;
                default: sub_last = 8'hFF;
            endcase
        end

        // clock phase at 1:1, prescaler bits otherwise
        assign ext = sub_nxt[{psc_r, 1'b0} +: 2]; // RL7

        always @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                per_r <= `PDT_PER_RST;
                psc_r <= `PDT_PSC_RST;
                run_r <= 1'b0;
            end
            else if (sel_w)
            begin
                if (pstrb[0])
                    per_r <= pwdata[`PDT_TMR_PER_LSB +: 8];
                if (pstrb[1])
                begin
                    psc_r <= pwdata[`PDT_TMR_PSC_LSB +: 2];
                    run_r <= pwdata[`PDT_TMR_RUN_BIT];
                end
            end
        end

        // period restart on match with per_r
        always @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                sub_r <= 8'h00;
                cnt_r <= 8'h00;
            end
            else
            begin
                sub_r <= sub_nxt;
                cnt_r <= cnt_nxt;
            end
        end

        // time base of the coming cycle, so the registered pin lands on it
        assign tb_w[10*gi +: 10] = {cnt_nxt, ext}; // RL6
        assign pm_w[gi] = tick & (cnt_r == per_r); // RL3
        assign per_w[8*gi +: 8] = per_r;
        assign cnt_w[8*gi +: 8] = cnt_r;
        assign tcfg_w[11*gi +: 11] = {run_r, psc_r, per_r};
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// pwm channels

genvar gj;
generate
    for (gj = 0; gj < NUM_CH; gj = gj + 1)
    begin : g_ch
        reg en_r;
        reg fmt_r;
        reg [7:0] dl_r;
        reg [7:0] dh_r;
        reg [9:0] buf_r;
        reg out_r;
        reg [9:0] tb;
        reg pm;
        reg [7:0] per;
        wire [1:0] sel;
        wire [9:0] duty_new;
        wire [10:0] full;

        assign sel = tmrsel_r[2*gj +: 2];

        // route the chosen timer; 00 leaves the channel idle
        always @*
        begin
            case (sel)
                2'b01:
                begin
                    tb = tb_w[9:0]; // RL11
                    pm = pm_w[0];
                    per = per_w[7:0];
                end
                2'b10:
                begin
                    tb = tb_w[19:10]; // RL11
                    pm = pm_w[1];
                    per = per_w[15:8];
                end
                2'b11:
                begin
                    tb = tb_w[29:20]; // RL11
                    pm = pm_w[2];
                    per = per_w[23:16];
                end
                default:
                begin
                    tb = 10'h000;
                    pm = 1'b0;
                    per = 8'h00;
                end
            endcase
        end

        assign duty_new = fmt_r ? {dh_r, dl_r[7:6]} : {dh_r[1:0], dl_r}; // RL1 RL2
        assign full = {1'b0, per, 2'b11} + 11'h001;

        always @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                en_r <= 1'b0;
                fmt_r <= 1'b0;
                dl_r <= 8'h00;
                dh_r <= 8'h00;
            end
            else if (wr_en & pstrb[0])
            begin
                if (addr8 == ch_addr(gj, `PDT_CH_CTRL))
                begin
                    en_r <= pwdata[`PDT_CH_EN_BIT];
                    fmt_r <= pwdata[`PDT_CH_FMT_BIT]; // RL2
                end
                if (addr8 == ch_addr(gj, `PDT_CH_DUTYL))
                    dl_r <= pwdata[7:0]; // RL1
                if (addr8 == ch_addr(gj, `PDT_CH_DUTYH))
                    dh_r <= pwdata[7:0]; // RL1
            end
        end

        always @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                buf_r <= 10'h000;
                out_r <= 1'b0;
            end
            else if (!en_r || sel == 2'b00)
                out_r <= 1'b0;
            else if (pm)
            begin
                buf_r <= duty_new; // RL3
                if (duty_new == 10'h000)
                    out_r <= 1'b0; // RL13
                else if ({1'b0, duty_new} > full)
                    out_r <= out_r; // RL10
                else
                    out_r <= 1'b1; // RL13 RL4
            end
            else if (tb == buf_r)
                out_r <= 1'b0; // RL8 RL4
        end

        assign pwm_out_pin[gj] = out_r;
        assign chrd_w[28*gj +: 28] = {15'h0000, fmt_r, en_r, out_r, buf_r};
        assign duty_w[16*gj +: 16] = {dh_r, dl_r};
    end
endgenerate

endmodule // pdt_pwm_duty_timebase

/* File: pdt_checker.sv */
`timescale 1ns/100ps
module pdt_checker #(
    parameter NUM_CH = 4,
    parameter ADDR_W = 8
) (
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [NUM_CH-1:0] pwm_out_pin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire acc = psel && penable;
    wire hole = paddr >= 8'h50 || paddr[1:0] != 2'h0 || (paddr >= 8'h10 && paddr[3:2] == 2'h3);
    ////////////////
    a_ready_access: assert property (acc |-> pready) else $error("no pready");
    a_ready_idle: assert property (!acc |-> !pready && !pslverr) else $error("stray answer");
    a_refuse_hole: assert property (acc && hole |-> pslverr) else $error("hole accepted");
    a_accept_mapped: assert property (acc && !hole |-> !pslverr) else $error("mapped refused");
    a_refuse_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused data");
    a_select_width: assert property (acc && !pwrite && paddr == 8'h0C |-> prdata[31:8] == 24'h0)
        else $error("select width");
    a_reset_quiet: assert property ($rose(resetn) |-> pwm_out_pin == 0 && prdata == 32'h0)
        else $error("pin after reset");
    a_read_stands: assert property (acc ##1 !psel |-> $stable(prdata)) else $error("prdata moved");
    c_refused: cover property (acc && pslverr);
    c_pin_rise: cover property ($rose(pwm_out_pin[0]));
    c_pin_fall: cover property ($fell(pwm_out_pin[0]));
endmodule // pdt_checker

bind pdt_pwm_duty_timebase pdt_checker #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) u_pdt_checker (.clk(clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out_pin(pwm_out_pin));

/* File: pdt_load.sv */
`timescale 1ns/100ps
module pdt_load (
    input wire clk,
    input wire pin,
    output reg [31:0] hi_len = 32'h0,
    output reg [31:0] per_len = 32'h0,
    output reg [31:0] rises = 32'h0
);
    reg [31:0] hi_run = 32'h0;
    reg [31:0] per_run = 32'h0;
    reg prev = 1'b0;
    // measures last high time and last period
    always @(posedge clk)
    begin
        prev <= pin;
        per_run <= (pin && !prev) ? 32'h1 : per_run + 32'h1;
        hi_run <= pin ? hi_run + 32'h1 : 32'h0;
        if (!pin && prev)
            hi_len <= hi_run;
        if (pin && !prev)
        begin
            rises <= rises + 32'h1;
            per_len <= per_run;
        end
    end
endmodule // pdt_load

/* File: test_pwm_duty_timebase.sv */
`timescale 1ns/100ps
`include "pdt_consts.vh"
module test_pwm_duty_timebase;
    reg clk;
    reg resetn;
    reg psel;
    reg penable;
    reg pwrite;
    reg [7:0] paddr;
    reg [31:0] pwdata;
    reg [3:0] pstrb;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [3:0] pwm_out_pin;
    wire [31:0] hi_len;
    wire [31:0] per_len;
    wire [31:0] rises;
    integer mismatches = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer i;
    integer k;
    reg [31:0] rd;
    reg err;
    reg [71:0] rows [0:9];
    pdt_pwm_duty_timebase u_pdt_pwm_duty_timebase (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out_pin(pwm_out_pin));
    pdt_load u_pdt_load (.clk(clk), .pin(pwm_out_pin[0]), .hi_len(hi_len), .per_len(per_len), .rises(rises));
    ////////////////
    task apb(input w, input [7:0] a, input [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (!pready)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    end
    endtask
    task pwm(input [7:0] sel, input [7:0] ta, input fmt, input [7:0] lo, input [1:0] psc, input [9:0] d);
        integer n;
        integer r0;
    begin
        n = 1 << (2 * psc);
        apb(1, `PDT_TMRSEL, {24'h0, sel});
        apb(1, 8'h14, {24'h0, lo});
        apb(1, 8'h18, 32'h0);
        apb(1, 8'h10, {30'h0, fmt, 1'b1});
        r0 = rises;
        apb(1, ta, {21'h0, 1'b1, psc, 8'h00});
        i = 0;
        while (rises < r0 + 3 && i < 4000)
        begin
            @(posedge clk);
            i = i + 1;
        end
        chk("rises", r0 + 3, rises);
        chk("others", 32'h0, {29'h0, pwm_out_pin[3:1]});
        chk("high", d * n, hi_len);
        chk("period", 4 * n, per_len);
        apb(0, 8'h10, 32'h0);
        chk("buffer", {22'h0, d}, {22'h0, rd[25:16]});
        apb(1, ta, 32'hFF);
        $display("pwm test done");
    end
    endtask
    task end_of_test;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    ////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            mismatches = mismatches + 1;
            end_of_test;
        end
    end
    initial
    begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = 0;
        pstrb = 4'hF;
        rows[0] = {8'h0C, 32'hE4, 32'hE4};
        rows[1] = {8'h00, 32'h3AB, 32'h3AB};
        rows[2] = {8'h14, 32'hAB, 32'hAB};
        rows[3] = {8'h18, 32'hFF, 32'hFF};
        rows[4] = {8'h10, 32'h2, 32'h2};
        rows[5] = {8'h0C, 32'h55, 32'h55};
        rows[6] = {8'h00, 32'hFF, 32'hFF};
        rows[7] = {8'h14, 32'h0, 32'h0};
        rows[8] = {8'h18, 32'h0, 32'h0};
        rows[9] = {8'h10, 32'h0, 32'h0};
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        apb(0, `PDT_TMRSEL, 32'h0);
        chk("select", 32'h55, rd);
        apb(0, 8'h00, 32'h0);
        chk("timer", 32'hFF, rd);
        $display("reset test done");
        for (k = 0; k < 10; k = k + 1)
        begin
            apb(1, rows[k][71:64], rows[k][63:32]);
            apb(0, rows[k][71:64], 32'h0);
            chk("row", rows[k][31:0], rd);
        end
        $display("row test done");
        pwm(8'h55, 8'h00, 1'b0, 8'h02, 2'h0, 10'h2);
        pwm(8'h56, 8'h04, 1'b1, 8'h80, 2'h1, 10'h2);
        pwm(8'h57, 8'h08, 1'b0, 8'h03, 2'h3, 10'h3);
        apb(1, 8'h14, 32'h0);
        k = rises;
        apb(1, 8'h08, 32'h400);
        repeat (40) @(posedge clk);
        chk("zero", 32'h0, {31'h0, pwm_out_pin[0]});
        chk("zero rises", k, rises);
        apb(0, 8'h50, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("rdata", 32'h0, rd);
        apb(1, 8'h1C, 32'hFF);
        chk("hole", 32'h1, {31'h0, err});
        $display("edge test done");
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("reset pin", 32'h0, {28'h0, pwm_out_pin});
        apb(0, `PDT_TMRSEL, 32'h0);
        chk("reset select", 32'h55, rd);
        $display("midrun reset test done");
        end_of_test;
    end
endmodule // test_pwm_duty_timebase
